// ### logic/qns_handler.sv
`timescale 1ns/1ps
// What this block does
// - Feature nibble 1h selects deadline handling
// - Supported deadline handling completes without error
// - Success sends set device bits completion
// - Abort deadline handling when queuing disabled
// - Abort when target tag equals own tag
// - Abort when target tag is invalid
// - Abort on unsupported abort type parameter
// - Write strict clear lets writes overrun limit
// - Write strict set: overrun aborts all outstanding
// - Write strict applies only to isochronous writes
// - Read strict clear lets reads overrun limit
// - Read strict set: overrun aborts all outstanding
// - Read strict applies only to isochronous reads
// - Feature nibble 5h selects queued set features
// - Completion notice sets interrupt and per-tag bits
// - Success reports error flag zero, error zero
// - Early error sends register FIS with error
`include "qns_regs.svh"
module qns_handler #(
  parameter int unsigned MAX_TAG = 31
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  input  wire logic                   ncq_enabled,
  input  wire logic                   abort_type_ok,
  input  wire logic                   cmd_valid,
  input  wire qns_pkg::qns_cmd_t      cmd,
  input  wire logic                   io_done,
  input  wire qns_pkg::qns_io_t       io_info,
  input  wire logic                   io_late,
  input  wire logic                   notify_ready,
  output logic                        cmd_busy,
  output logic [7:0]                  command_status_flags,
  output logic [7:0]                  command_error_flags,
  output logic                        sdb_valid,
  output logic                        sdb_interrupt,
  output logic [31:0]                 sdb_act,
  output logic                        d2h_valid,
  output logic                        abort_all,
  output logic                        write_deadline_strict,
  output logic                        read_deadline_strict,
  output logic                        setfeat_valid,
  output qns_pkg::qns_setfeat_t       setfeat
);
  import qns_pkg::*;

  logic [4:0]   tag;
  logic [4:0]   target_queue_tag;
  logic [3:0]   sub;

  logic         rej_ncq_off;
  logic         rej_self_tag;
  logic         rej_bad_tag;
  logic         rej_abort_type;
  logic         reject;

  logic         cmd_take;
  logic         cmd_finish;
  logic         finish_ok;
  logic         notify_fire;
  logic [31:0]  done_mask;
  logic         late_isoch;

  logic [31:0]  pend_reg;
  logic [31:0]  pend_next;
  logic [31:0]  act_reg;
  logic [31:0]  act_next;
  logic         sdbv_reg;
  logic         sdbv_next;

  logic         busy_reg;
  logic         busy_next;
  logic         d2h_reg;
  logic         d2h_next;
  logic [7:0]   sts_reg;
  logic [7:0]   sts_next;
  logic [7:0]   err_reg;
  logic [7:0]   err_next;

  logic         abt_reg;
  logic         abt_next;
  logic         ws_reg;
  logic         ws_next;
  logic         rs_reg;
  logic         rs_next;

  logic         sfv_reg;
  logic         sfv_next;
  qns_setfeat_t sf_reg;
  qns_setfeat_t sf_next;

  function automatic logic [31:0] tag_bit(input logic [4:0] t);
    tag_bit = 32'h1 << t;
  endfunction : tag_bit

  function automatic logic [7:0] bit_mask(input int unsigned pos);
    bit_mask = 8'(1 << pos);
  endfunction : bit_mask

  // Ready always shows; busy and error are the only bits this block moves
  function automatic logic [7:0] status_word(input logic busy, input logic err);
    status_word = `QNS_STS_IDLE;
    if (busy) status_word = status_word | bit_mask(`QNS_STS_BUSY_BIT);
    if (err) status_word = status_word | bit_mask(`QNS_STS_ERR_BIT);
  endfunction : status_word

  // Tags above the queue depth cannot name an outstanding command
  function automatic logic tag_in_range(input logic [4:0] t);
    tag_in_range = 32'(t) <= MAX_TAG;
  endfunction : tag_in_range

  // Set features has no checks of its own; deadline handling must pass all four
  function automatic logic sub_ok(input logic [3:0] s, input logic rej);
    sub_ok = (s == `QNS_SUB_DEADLINE && !rej) || (s == `QNS_SUB_SETFEAT);
  endfunction : sub_ok

  assign tag              = cmd.scnt_cur[`QNS_TAG_HI:`QNS_TAG_LO];
  assign target_queue_tag = cmd.snum_cur[`QNS_TAG_HI:`QNS_TAG_LO];
  assign sub              = cmd.feat_cur[`QNS_SUB_HI:`QNS_SUB_LO];

  // Abort type support is one input; the block does not decode the type itself
  assign rej_ncq_off      = !ncq_enabled;
  assign rej_self_tag     = (target_queue_tag == tag);
  assign rej_bad_tag      = !tag_in_range(target_queue_tag);
  assign rej_abort_type   = !abort_type_ok;
  assign reject           = rej_ncq_off | rej_self_tag | rej_bad_tag | rej_abort_type;

  assign cmd_take         = cmd_valid && !busy_reg;
  assign cmd_finish       = busy_reg;
  assign finish_ok        = cmd_finish && sub_ok(sub, reject);
  assign notify_fire      = !sdbv_reg && notify_ready && (pend_reg != 32'h0);
  assign done_mask        = io_done ? tag_bit(io_info.tag) : 32'h0;
  assign late_isoch       = io_done && io_late && (io_info.priority_class == `QNS_PRIORITY_CLASS_ISOCH);

  // A late isochronous transfer under the strict flag for its direction poisons the whole queue
  always_comb begin
    abt_next = 1'b0;
    if (late_isoch) begin
      if (io_info.is_write) begin
        abt_next = ws_reg;
      end else begin
        abt_next = rs_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      abt_reg <= 1'b0;
    end else if (clk_en) begin
      abt_reg <= abt_next;
    end
  end

  always_comb begin
    busy_next = busy_reg;
    d2h_next  = 1'b0;
    if (cmd_take) begin
      busy_next = 1'b1;
    end else if (cmd_finish) begin
      busy_next = 1'b0;
      // Error found while still busy, so a register FIS carries it
      d2h_next  = !finish_ok;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      d2h_reg  <= 1'b0;
    end else if (clk_en) begin
      busy_reg <= busy_next;
      d2h_reg  <= d2h_next;
    end
  end

  always_comb begin
    sts_next = sts_reg;
    err_next = err_reg;
    if (cmd_take) begin
      sts_next = status_word(1'b1, 1'b0);
    end else if (finish_ok) begin
      sts_next = status_word(1'b0, 1'b0);
      err_next = `QNS_ERR_NONE;
    end else if (cmd_finish) begin
      sts_next = status_word(1'b0, 1'b1);
      err_next = bit_mask(`QNS_ERR_ABORT_BIT);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sts_reg <= `QNS_STS_RESET;
      err_reg <= `QNS_ERR_NONE;
    end else if (clk_en) begin
      sts_reg <= sts_next;
      err_reg <= err_next;
    end
  end

  // Strict flags stay in force until the next deadline handling command that completes without error
  always_comb begin
    ws_next = ws_reg;
    rs_next = rs_reg;
    if (finish_ok && sub == `QNS_SUB_DEADLINE) begin
      ws_next = cmd.feat_cur[`QNS_BIT_WSTRICT];
      rs_next = cmd.feat_cur[`QNS_BIT_RSTRICT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ws_reg <= 1'b0;
      rs_reg <= 1'b0;
    end else if (clk_en) begin
      ws_reg <= ws_next;
      rs_reg <= rs_next;
    end
  end

  // Only the fields are handed on; the feature itself is acted on elsewhere
  always_comb begin
    sf_next  = sf_reg;
    sfv_next = 1'b0;
    if (cmd_finish && sub == `QNS_SUB_SETFEAT) begin
      sf_next.feature = cmd.feat_prev;
      sf_next.lba_lo  = cmd.scnt_prev;
      sf_next.lba_hi  = cmd.chigh_cur;
      sfv_next        = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfv_reg <= 1'b0;
      sf_reg  <= '0;
    end else if (clk_en) begin
      sfv_reg <= sfv_next;
      sf_reg  <= sf_next;
    end
  end

  // Notify batches all tags done since the last notice
  always_comb begin
    act_next  = act_reg;
    sdbv_next = 1'b0;
    if (notify_fire) begin
      sdbv_next = 1'b1;
      act_next  = pend_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdbv_reg <= 1'b0;
      act_reg  <= 32'h0;
    end else if (clk_en) begin
      sdbv_reg <= sdbv_next;
      act_reg  <= act_next;
    end
  end

  // A tag finishing in the cycle of a notice must survive the clear
  always_comb begin
    pend_next = pend_reg | done_mask;
    if (notify_fire) begin
      pend_next = done_mask;
    end
    if (finish_ok) begin
      pend_next = pend_next | tag_bit(tag);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_reg <= 32'h0;
    end else if (clk_en) begin
      pend_reg <= pend_next;
    end
  end

  assign cmd_busy              = busy_reg;
  assign command_status_flags  = sts_reg;
  assign command_error_flags   = err_reg;
  assign sdb_valid             = sdbv_reg;
  assign sdb_interrupt         = sdbv_reg;
  assign sdb_act               = act_reg;
  assign d2h_valid             = d2h_reg;
  assign abort_all             = abt_reg;
  assign write_deadline_strict = ws_reg;
  assign read_deadline_strict  = rs_reg;
  assign setfeat_valid         = sfv_reg;
  assign setfeat               = sf_reg;
endmodule : qns_handler

// ### logic/qns_pkg.sv
package qns_pkg;
  typedef struct packed {
    logic [7:0] feat_cur;
    logic [7:0] feat_prev;
    logic [7:0] scnt_cur;
    logic [7:0] scnt_prev;
    logic [7:0] snum_cur;
    logic [7:0] chigh_cur;
  } qns_cmd_t;
  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] lba_lo;
    logic [7:0] lba_hi;
  } qns_setfeat_t;
  typedef struct packed {
    logic        is_write;
    logic [1:0]  priority_class;
    logic [4:0]  tag;
  } qns_io_t;
endpackage : qns_pkg

// ### logic/qns_regs.svh
`ifndef QNS_REGS_SVH
`define QNS_REGS_SVH
`define QNS_SUB_DEADLINE     4'h1
`define QNS_SUB_SETFEAT      4'h5
`define QNS_SUB_HI           3
`define QNS_SUB_LO           0
`define QNS_BIT_WSTRICT      4
`define QNS_BIT_RSTRICT      5
`define QNS_TAG_HI           7
`define QNS_TAG_LO           3
`define QNS_PRIORITY_CLASS_ISOCH       2'h1
`define QNS_ERR_ABORT_BIT    2
`define QNS_STS_BUSY_BIT     7
`define QNS_STS_READY_BIT    6
`define QNS_STS_DRQ_BIT      3
`define QNS_STS_ERR_BIT      0
`define QNS_STS_IDLE         8'h40
`define QNS_ERR_NONE         8'h00
`define QNS_STS_RESET        8'h40
`endif

// ### tb/qns_chk.sv
`timescale 1ns/1ps
module qns_chk (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire qns_pkg::qns_cmd_t cmd,
  input wire logic              ncq_enabled,
  input wire logic              io_done,
  input wire qns_pkg::qns_io_t  io_info,
  input wire logic              io_late,
  input wire logic              notify_ready,
  input wire logic              cmd_busy,
  input wire logic [7:0]        command_status_flags,
  input wire logic [7:0]        command_error_flags,
  input wire logic              sdb_valid,
  input wire logic              sdb_interrupt,
  input wire logic [31:0]       sdb_act,
  input wire logic              d2h_valid,
  input wire logic              abort_all,
  input wire logic              write_deadline_strict
);
  import qns_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_done; $fell(cmd_busy) && !d2h_valid; endsequence
  sequence s_new; $rose(cmd_busy); endsequence
  property p_ok; s_done |-> command_status_flags == 8'h40 && command_error_flags == 8'h00;
  endproperty
  property p_err; d2h_valid |-> $fell(cmd_busy) && command_status_flags == 8'h41 &&
    command_error_flags == 8'h04; endproperty
  property p_sdb; s_done ##0 (notify_ready && !sdb_valid) |=> sdb_valid && sdb_interrupt;
  endproperty
  property p_act; sdb_valid |-> sdb_interrupt && sdb_act != 32'h0; endproperty
  property p_ncq; s_new ##0 (!ncq_enabled && cmd.feat_cur[3:0] == 4'h1) |=> d2h_valid;
  endproperty
  property p_sub; s_new ##0 !(cmd.feat_cur[3:0] inside {4'h1, 4'h5}) |=> d2h_valid;
  endproperty
  property p_wstr; io_done && io_late && io_info.is_write && io_info.priority_class == 2'h1 &&
    write_deadline_strict |=> abort_all; endproperty
  property p_cause; abort_all |-> $past(io_done) && $past(io_late) && $past(io_info[6:5]) == 2'h1;
  endproperty
  property p_strict; s_done ##0 $past(cmd[43:40]) == 4'h1 |->
    write_deadline_strict == $past(cmd[44]); endproperty
  a_ok: assert property (p_ok) else $error("bad success status");
  a_err: assert property (p_err) else $error("bad error report");
  a_sdb: assert property (p_sdb) else $error("missing completion notice");
  a_act: assert property (p_act) else $error("empty completion notice");
  a_ncq: assert property (p_ncq) else $error("queuing off not refused");
  a_sub: assert property (p_sub) else $error("unknown code not refused");
  a_wstr: assert property (p_wstr) else $error("late write not aborted");
  a_cause: assert property (p_cause) else $error("abort without cause");
  a_strict: assert property (p_strict) else $error("strict flag wrong");
endmodule : qns_chk
bind qns_handler qns_chk chk_u (.*);

// ### tb/qns_host.sv
`timescale 1ns/1ps
module qns_host (
  input  wire logic        clk,
  input  wire logic        cmd_busy,
  output qns_pkg::qns_cmd_t cmd,
  output logic             cmd_valid
);
  import qns_pkg::*;
  initial cmd = '0;
  initial cmd_valid = 1'b0;
  // Fields scrambled after completion so a design that fails to latch them shows it
  task issue(input qns_cmd_t c);
    int n;
    cmd = c;
    cmd_valid = 1'b1;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (!cmd_busy && n < 50);
    cmd_valid = 1'b0;
    do begin @(posedge clk); #1; n++; end while (cmd_busy && n < 50);
    cmd = ~c;
  endtask : issue
endmodule : qns_host

// ### tb/queued_nondata_subcmd_handler_tb_top.sv
`timescale 1ns/1ps
module queued_nondata_subcmd_handler_tb_top;
  import qns_pkg::*;
  logic clk = 0, sys_rst = 1, clk_en = 1, ncq_enabled = 1, abort_type_ok = 1;
  logic io_done = 0, io_late = 0, notify_ready = 1, cmd_valid, cmd_busy, sdb_valid;
  logic sdb_interrupt, d2h_valid, abort_all, write_deadline_strict, read_deadline_strict;
  logic [7:0] command_status_flags, command_error_flags;
  logic [31:0] sdb_act;
  logic setfeat_valid;
  qns_io_t io_info = '0;
  qns_cmd_t cmd, c;
  qns_setfeat_t setfeat, sf_seen;
  int err_total = 0, n_tests = 0;
  always #25 clk = ~clk;
  qns_handler #(.MAX_TAG(7)) dut_u (.*);
  qns_host host_u (.clk(clk), .cmd_busy(cmd_busy), .cmd(cmd), .cmd_valid(cmd_valid));
  always @(posedge clk) if (setfeat_valid) sf_seen <= setfeat;
  task summarize;
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic qns_cmd_t mk(input logic [7:0] f, input logic [4:0] tg, input logic [4:0] tt);
    mk = '0;
    mk.feat_cur = f;
    mk.scnt_cur = {tg, 3'h0};
    mk.snum_cur = {tt, 3'h0};
  endfunction : mk
  task run(input qns_cmd_t q, input logic bad);
    host_u.issue(q);
    chk(d2h_valid, bad);
    chk(command_status_flags, bad ? 8'h41 : 8'h40);
    chk(command_error_flags, bad ? 8'h04 : 8'h00);
    @(posedge clk); #1;
    chk(sdb_valid & sdb_interrupt, !bad);
    if (!bad) chk(sdb_act, 32'h1 << q.scnt_cur[7:3]);
  endtask : run
  task io(input logic w, input logic [1:0] p, input logic l, input logic e);
    logic ab;
    io_info = '{w, p, 5'h6};
    io_late = l;
    io_done = 1;
    @(posedge clk); #1;
    io_done = 0;
    ab = abort_all;
    @(posedge clk); #1;
    chk(ab | abort_all, e);
    repeat (2) @(posedge clk);
    #1;
  endtask : io
  task batch;
    notify_ready = 0;
    io_info = '{1'b0, 2'h0, 5'h2};
    io_done = 1;
    @(posedge clk);
    #1;
    io_done = 0;
    host_u.issue(mk(8'h01, 5'h5, 5'h1));
    chk(sdb_valid, 1'b0);
    notify_ready = 1;
    @(posedge clk);
    #1;
    chk(sdb_valid & sdb_interrupt, 1'b1);
    chk(sdb_act, 32'h24);
    @(posedge clk);
    #1;
    $display("batched notice done");
  endtask : batch
  task freeze;
    clk_en = 0;
    io_info = '{1'b1, 2'h0, 5'h7};
    io_done = 1;
    repeat (2) @(posedge clk);
    #1;
    io_done = 0;
    clk_en = 1;
    @(posedge clk);
    #1;
    chk(sdb_valid, 1'b0);
    @(posedge clk);
    #1;
    chk(sdb_act, 32'h24);
    $display("clock enable freeze done");
  endtask : freeze
  initial begin
    repeat (20) @(posedge clk);
    #1 sys_rst = 0;
    run(mk(8'h31, 5'h3, 5'h5), 0);
    chk({write_deadline_strict, read_deadline_strict}, 2'h3);
    $display("deadline accept done");
    io(1, 2'h1, 1, 1);
    io(1, 2'h2, 1, 0);
    io(0, 2'h1, 1, 1);
    io(0, 2'h0, 1, 0);
    io(1, 2'h1, 0, 0);
    run(mk(8'h01, 5'h3, 5'h5), 0);
    io(1, 2'h1, 1, 0);
    io(0, 2'h1, 1, 0);
    $display("strict flags done");
    ncq_enabled = 0;
    run(mk(8'h01, 5'h2, 5'h4), 1);
    ncq_enabled = 1;
    run(mk(8'h01, 5'h6, 5'h6), 1);
    run(mk(8'h01, 5'h2, 5'h9), 1);
    abort_type_ok = 0;
    run(mk(8'h01, 5'h2, 5'h4), 1);
    abort_type_ok = 1;
    for (int s = 0; s < 16; s++) if (s != 1 && s != 5) run(mk({4'h0, s[3:0]}, 5'h1, 5'h2), 1);
    $display("refusals done");
    c = mk(8'h05, 5'h4, 5'h0);
    c.feat_prev = 8'ha5;
    c.scnt_prev = 8'h3c;
    c.chigh_cur = 8'h7e;
    run(c, 0);
    chk(sf_seen, 24'ha53c7e);
    $display("set features done");
    batch;
    freeze;
    summarize;
  end
  initial begin
    #200000;
    err_total++;
    summarize;
  end
endmodule : queued_nondata_subcmd_handler_tb_top
